// ### adcsr_consts.svh
// constants of the adc conversion control and serial readout
// assumes a 125 MHz system clock on both ends
`ifndef ADCSR_CONSTS_SVH
`define ADCSR_CONSTS_SVH
`define ADCSR_CLK_MHZ 125
`define ADCSR_CONV_NS 3800
`define ADCSR_WAKE_NS 6000
`define ADCSR_SETTLE_NS 300
`define ADCSR_SCLK_MAX_MHZ 15
`define ADCSR_CONV_CYC ((`ADCSR_CONV_NS * `ADCSR_CLK_MHZ) / 1000)
`define ADCSR_WAKE_CYC ((`ADCSR_WAKE_NS * `ADCSR_CLK_MHZ + 999) / 1000)
`define ADCSR_SETTLE_CYC ((`ADCSR_SETTLE_NS * `ADCSR_CLK_MHZ + 999) / 1000)
`define ADCSR_SCLK_HALF ((`ADCSR_CLK_MHZ + 2 * `ADCSR_SCLK_MAX_MHZ - 1) / (2 * `ADCSR_SCLK_MAX_MHZ))
`define ADCSR_FRAME_BITS 16
`define ADCSR_LEAD_ZEROS 4
`define ADCSR_RES_BITS 12
`endif

// ### adcsr_pkg.sv
// types of the adc conversion control and serial readout
// assumes adcsr_consts.svh is available
package adcsr_pkg;
  typedef logic [11:0] adcsr_result_t;
  typedef enum logic [1:0] {
    ADCSR_AWAKE = 2'b00,
    ADCSR_CONV = 2'b01,
    ADCSR_SLEEP = 2'b10,
    ADCSR_WAKE = 2'b11
  } adcsr_dev_e;
  typedef enum logic [2:0] {
    ADCSR_H_IDLE = 3'b000,
    ADCSR_H_START = 3'b001,
    ADCSR_H_WAIT = 3'b010,
    ADCSR_H_READ = 3'b011,
    ADCSR_H_SETTLE = 3'b100
  } adcsr_host_e;
endpackage

// ### adcsr_if.sv
// four-wire link between converter and host, plus output enable
// assumes the bench ties both modports together
`timescale 1ns/1ns
interface adcsr_if;
  logic conversion_start_n;
  logic serial_clk;
  logic busy;
  logic serial_result_out;
  logic serial_result_oe;
  modport dev (
    input conversion_start_n,
    input serial_clk,
    output busy,
    output serial_result_out,
    output serial_result_oe
  );
  modport host (
    output conversion_start_n,
    output serial_clk,
    input busy,
    input serial_result_out,
    input serial_result_oe
  );
endinterface

// ### adcsr_sync.sv
// two-flop synchroniser with edge detect on the second stage
// assumes one system clock
`timescale 1ns/1ns
module adcsr_sync (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic async_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  logic meta_q;
  logic sync_q;
  logic last_q;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end
  assign level_o = sync_q;
  assign rise_o = sync_q & ~last_q;
  assign fall_o = ~sync_q & last_q;
endmodule

// ### adcsr_dev.sv
// converter end: conversion sequencing and serial readout
// assumes the host keeps its side of the link contract
`timescale 1ns/1ns
`include "adcsr_consts.svh"
module adcsr_dev
  import adcsr_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  adcsr_if.dev LINK,
  input wire logic [11:0] SAMPLE_I,
  output logic TRACK_O,
  output logic AWAKE_O
);
  logic start_lvl;
  logic start_rise;
  logic start_fall;
  logic sclk_lvl;
  logic sclk_rise;
  logic sclk_fall;
  adcsr_dev_e state_q;
  logic [15:0] timer_q;
  adcsr_result_t out_reg_q;
  logic [4:0] edge_cnt_q;
  logic busy_q;
  logic track_q;
  logic sdo_q;
  logic oe_q;
  logic awake_q;
  logic [15:0] frame;
  logic conv_end;

  adcsr_sync u_start (
    .clk_i(CLOCK_I),
    .rst_b_i(RST_B_I),
    .async_i(LINK.conversion_start_n),
    .level_o(start_lvl),
    .rise_o(start_rise),
    .fall_o(start_fall)
  );
  adcsr_sync u_sclk (
    .clk_i(CLOCK_I),
    .rst_b_i(RST_B_I),
    .async_i(LINK.serial_clk),
    .level_o(sclk_lvl),
    .rise_o(sclk_rise),
    .fall_o(sclk_fall)
  );

  assign conv_end = (state_q == ADCSR_CONV) && (timer_q == 16'h0001);
  // four zeros then result msb first
  assign frame = {4'h0, out_reg_q};

  // conversion sequencing on the system clock
  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      state_q <= ADCSR_AWAKE;
      timer_q <= 16'h0000;
      busy_q <= 1'b0;
      track_q <= 1'b1;
    end else begin
      case (state_q)
        ADCSR_AWAKE: begin
          if (start_fall) begin
            state_q <= ADCSR_CONV;
            timer_q <= 16'(`ADCSR_CONV_CYC);
            busy_q <= 1'b1;
            track_q <= 1'b0;
          end
        end
        ADCSR_CONV: begin
          timer_q <= timer_q - 16'h0001;
          if (conv_end) begin
            busy_q <= 1'b0;
            track_q <= 1'b1;
            state_q <= start_lvl ? ADCSR_AWAKE : ADCSR_SLEEP;
          end
        end
        ADCSR_SLEEP: begin
          if (start_rise) begin
            state_q <= ADCSR_WAKE;
            timer_q <= 16'(`ADCSR_WAKE_CYC);
          end
        end
        ADCSR_WAKE: begin
          if (timer_q > 16'h0001) begin
            timer_q <= timer_q - 16'h0001;
          end else if (!start_lvl) begin
            state_q <= ADCSR_CONV;
            timer_q <= 16'(`ADCSR_CONV_CYC);
            busy_q <= 1'b1;
            track_q <= 1'b0;
          end else begin
            timer_q <= 16'h0001;
          end
        end
        default: begin
          state_q <= ADCSR_AWAKE;
        end
      endcase
    end
  end

  // output register loads as busy falls
  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      out_reg_q <= 12'h000;
    end else if (conv_end) begin
      out_reg_q <= SAMPLE_I;
    end
  end

  // serial edge counter, kept across pauses
  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      edge_cnt_q <= 5'h00;
    end else if (start_fall && !sclk_lvl) begin
      edge_cnt_q <= 5'h00;
    end else if (sclk_fall) begin
      if (edge_cnt_q == 5'(`ADCSR_FRAME_BITS)) begin
        edge_cnt_q <= 5'h01;
      end else begin
        edge_cnt_q <= edge_cnt_q + 5'h01;
      end
    end
  end

  // data and enable on the serial output
  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (start_fall && !sclk_lvl) begin
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (sclk_rise && edge_cnt_q == 5'h00) begin
      sdo_q <= frame[15];
      oe_q <= 1'b1;
    end else if (sclk_rise && edge_cnt_q == 5'(`ADCSR_FRAME_BITS)) begin
      sdo_q <= frame[15];
      oe_q <= 1'b1;
    end else if (sclk_fall) begin
      if (edge_cnt_q == 5'(`ADCSR_FRAME_BITS - 1)) begin
        oe_q <= 1'b0;
      end else if (edge_cnt_q < 5'(`ADCSR_FRAME_BITS - 1)) begin
        sdo_q <= frame[4'(14 - edge_cnt_q)];
      end else begin
        sdo_q <= frame[14];
      end
    end
  end

  // registered awake flag
  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      awake_q <= 1'b1;
    end else begin
      awake_q <= (state_q != ADCSR_SLEEP);
    end
  end

  assign LINK.busy = busy_q;
  assign LINK.serial_result_out = sdo_q;
  assign LINK.serial_result_oe = oe_q;
  assign TRACK_O = track_q;
  assign AWAKE_O = awake_q;
endmodule

// ### adcsr_host.sv
// host end: starts conversions and reads sixteen-bit frames
// assumes the converter end keeps its side of the link contract
`timescale 1ns/1ns
`include "adcsr_consts.svh"
module adcsr_host
  import adcsr_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  adcsr_if.host LINK,
  input wire logic GO_I,
  input wire logic SLEEP_MODE_I,
  output logic [11:0] RESULT_O,
  output logic DONE_O
);
  logic busy_lvl;
  logic busy_fall;
  logic sdo_lvl;
  adcsr_host_e state_q;
  logic [7:0] cnt_q;
  logic [4:0] bit_q;
  logic sclk_q;
  logic start_n_q;
  logic [15:0] shift_q;
  logic [11:0] result_q;
  logic done_q;
  logic mode_q;

  adcsr_sync u_busy (
    .clk_i(CLOCK_I),
    .rst_b_i(RST_B_I),
    .async_i(LINK.busy),
    .level_o(busy_lvl),
    .rise_o(),
    .fall_o(busy_fall)
  );
  adcsr_sync u_sdo (
    .clk_i(CLOCK_I),
    .rst_b_i(RST_B_I),
    .async_i(LINK.serial_result_out),
    .level_o(sdo_lvl),
    .rise_o(),
    .fall_o()
  );

  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      state_q <= ADCSR_H_IDLE;
      cnt_q <= 8'h00;
      bit_q <= 5'h00;
      sclk_q <= 1'b0;
      start_n_q <= 1'b1;
      shift_q <= 16'h0000;
      result_q <= 12'h000;
      done_q <= 1'b0;
      mode_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        ADCSR_H_IDLE: begin
          sclk_q <= 1'b0;
          if (GO_I) begin
            start_n_q <= 1'b1;
            mode_q <= SLEEP_MODE_I;
            cnt_q <= 8'(`ADCSR_SCLK_HALF);
            state_q <= ADCSR_H_START;
          end
        end
        ADCSR_H_START: begin
          if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
          end else if (busy_lvl) begin
            start_n_q <= mode_q ? 1'b0 : 1'b1;
            state_q <= ADCSR_H_WAIT;
          end else begin
            start_n_q <= 1'b0;
          end
        end
        ADCSR_H_WAIT: begin
          if (busy_fall) begin
            bit_q <= 5'h00;
            cnt_q <= 8'(`ADCSR_SCLK_HALF);
            state_q <= ADCSR_H_READ;
          end
        end
        ADCSR_H_READ: begin
          if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
          end else begin
            cnt_q <= 8'(`ADCSR_SCLK_HALF);
            sclk_q <= ~sclk_q;
            if (sclk_q) begin
              shift_q <= {shift_q[14:0], sdo_lvl};
              bit_q <= bit_q + 5'h01;
              if (bit_q == 5'(`ADCSR_FRAME_BITS - 1)) begin
                cnt_q <= 8'(`ADCSR_SETTLE_CYC);
                state_q <= ADCSR_H_SETTLE;
              end
            end
          end
        end
        ADCSR_H_SETTLE: begin
          sclk_q <= 1'b0;
          if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
          end else begin
            result_q <= shift_q[11:0];
            done_q <= 1'b1;
            state_q <= ADCSR_H_IDLE;
          end
        end
        default: begin
          state_q <= ADCSR_H_IDLE;
        end
      endcase
    end
  end

  assign LINK.conversion_start_n = start_n_q;
  assign LINK.serial_clk = sclk_q;
  assign RESULT_O = result_q;
  assign DONE_O = done_q;
endmodule

// ### adcsr_checker.sv
// timing checks on the four-wire link between the two ends, plus output enable
// assumes it sits beside the link interface in the bench
`timescale 1ns/1ns
module adcsr_checker (
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  input wire logic conversion_start_n,
  input wire logic serial_clk,
  input wire logic busy,
  input wire logic serial_result_out,
  input wire logic serial_result_oe
);
  localparam int CONV_LO = 468;
  localparam int CONV_HI = 476;
  localparam int WAKE_LO = 745;
  logic sleep_q;
  logic [9:0] busy_cnt_q;
  logic [9:0] wake_cnt_q;
  logic [4:0] fall_cnt_q;
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_B_I);
  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I) sleep_q <= 1'b0;
    else if ($fell(busy)) sleep_q <= !conversion_start_n;
    else if ($rose(busy)) sleep_q <= 1'b0;
  end
  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I || !busy) busy_cnt_q <= 10'h000;
    else if (busy_cnt_q != 10'h3ff) busy_cnt_q <= busy_cnt_q + 10'h001;
  end
  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I || $rose(conversion_start_n)) wake_cnt_q <= 10'h000;
    else if (wake_cnt_q != 10'h3ff) wake_cnt_q <= wake_cnt_q + 10'h001;
  end
  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I || ($fell(conversion_start_n) && !serial_clk)) fall_cnt_q <= 5'h00;
    else if ($fell(serial_clk)) fall_cnt_q <= (fall_cnt_q == 5'h0f) ? 5'h00 : fall_cnt_q + 5'h01;
  end
  sequence last_fall_s;
    $fell(serial_clk) && fall_cnt_q == 5'h0f;
  endsequence
  sequence hold_release_s;
    serial_result_oe ##[1:5] !serial_result_oe;
  endsequence
  start_busy_a: assert property (
    $fell(conversion_start_n) && !busy && !sleep_q |-> ##[1:6] busy)
    else $error("busy did not follow start");
  conv_length_a: assert property (
    $fell(busy) |-> busy_cnt_q inside {[CONV_LO:CONV_HI]})
    else $error("conversion length wrong");
  wake_hold_a: assert property (
    $rose(busy) && sleep_q |-> wake_cnt_q >= WAKE_LO)
    else $error("hold before wake time");
  frame_end_a: assert property (last_fall_s |-> hold_release_s)
    else $error("output not released after frame");
  first_zero_a: assert property (
    $rose(serial_result_oe) |-> serial_clk && fall_cnt_q == 5'h00 && !serial_result_out)
    else $error("output enabled out of place");
  lead_zero_a: assert property (
    $fell(serial_clk) && fall_cnt_q < 5'h03 |-> ##5 serial_result_oe && !serial_result_out)
    else $error("leading bit not zero");
  bit_change_a: assert property (
    serial_result_oe && $past(serial_result_oe) && $changed(serial_result_out) |-> !serial_clk)
    else $error("data changed with clock high");
  host_start_a: assert property ($fell(conversion_start_n) |-> !serial_clk)
    else $error("start fell with clock high");
  host_wait_a: assert property (busy |-> !serial_clk)
    else $error("clock moved during conversion");
endmodule

// ### tb_adc_conversion_control_serial_readout.sv
// bench: host and converter ends joined, plus a bench-driven converter
// assumes design files and checker are compiled first
`timescale 1ns/1ns
module tb_adc_conversion_control_serial_readout import adcsr_pkg::*;;
  typedef struct packed {logic slp; adcsr_result_t smp; adcsr_result_t res; logic awk;} adcsr_row_s;
  adcsr_row_s rows [6] = '{'{1'b0, 12'h000, 12'h000, 1'b1}, '{1'b0, 12'hfff, 12'hfff, 1'b1},
    '{1'b1, 12'h800, 12'h800, 1'b0}, '{1'b1, 12'h7ff, 12'h7ff, 1'b0},
    '{1'b0, 12'ha5a, 12'ha5a, 1'b1}, '{1'b1, 12'h5a5, 12'h5a5, 1'b0}};
  logic clk, rst_b, go, sleep_mode, done, trk, awk, trk2, awk2;
  adcsr_result_t sample, sample2, result;
  logic [15:0] frame;
  int num_errors = 0;
  int checks = 0;
  adcsr_if lk ();
  adcsr_if lk2 ();
  adcsr_dev u_adcsr_dev (.CLOCK_I(clk), .RST_B_I(rst_b), .LINK(lk.dev), .SAMPLE_I(sample),
    .TRACK_O(trk), .AWAKE_O(awk));
  adcsr_host u_adcsr_host (.CLOCK_I(clk), .RST_B_I(rst_b), .LINK(lk.host), .GO_I(go),
    .SLEEP_MODE_I(sleep_mode), .RESULT_O(result), .DONE_O(done));
  adcsr_dev u_adcsr_dev_b (.CLOCK_I(clk), .RST_B_I(rst_b), .LINK(lk2.dev), .SAMPLE_I(sample2),
    .TRACK_O(trk2), .AWAKE_O(awk2));
  adcsr_checker u_adcsr_checker (.CLOCK_I(clk), .RST_B_I(rst_b),
    .conversion_start_n(lk.conversion_start_n), .serial_clk(lk.serial_clk), .busy(lk.busy),
    .serial_result_out(lk.serial_result_out), .serial_result_oe(lk.serial_result_oe));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic bits2(input int n);
    repeat (n) begin
      lk2.serial_clk = 1'b1;
      tick(8);
      frame = {frame[14:0], lk2.serial_result_out};
      lk2.serial_clk = 1'b0;
      tick(8);
    end
  endtask
  task automatic start2(input logic hold_low);
    lk2.conversion_start_n = 1'b0;
    tick(5);
    chk(16'(lk2.busy), 16'h0001);
    if (!hold_low) lk2.conversion_start_n = 1'b1;
    for (int k = 0; k < 475 && lk2.busy; k++) tick(1);
    chk(16'(lk2.busy), 16'h0000);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #400000;
    num_errors++;
    give_verdict();
  end
  initial begin
    {rst_b, go, sleep_mode, sample, sample2, frame} = '0;
    lk2.conversion_start_n = 1'b1;
    lk2.serial_clk = 1'b0;
    tick(8);
    rst_b = 1'b1;
    tick(2);
    chk(16'(lk.serial_result_oe), 16'h0000);
    foreach (rows[i]) begin
      sample = rows[i].smp;
      sleep_mode = rows[i].slp;
      go = 1'b1;
      tick(1);
      go = 1'b0;
      for (int k = 0; k < 3000 && done !== 1'b1; k++) tick(1);
      chk(16'(result), 16'(rows[i].res));
      chk(16'(awk), 16'(rows[i].awk));
      chk(16'(trk), 16'h0001);
      $display("row %0d done", i);
    end
    sample2 = 12'hc3a;
    start2(1'b0);
    bits2(8);
    tick(100);
    bits2(8);
    chk(frame, {4'h0, sample2});
    tick(4);
    chk(16'(lk2.serial_result_oe), 16'h0000);
    bits2(4);
    tick(20);
    chk(16'(lk2.serial_result_oe), 16'h0001);
    chk(16'(frame[3:0]), 16'h0000);
    $display("pause and extra clocks done");
    sample2 = 12'h35c;
    tick(40);
    start2(1'b1);
    tick(5);
    chk(16'(awk2), 16'h0000);
    bits2(16);
    chk(frame, {4'h0, sample2});
    $display("clear and sleep read done");
    sample2 = 12'h9e1;
    lk2.conversion_start_n = 1'b1;
    tick(800);
    chk(16'(lk2.busy), 16'h0000);
    chk(16'(awk2), 16'h0001);
    start2(1'b0);
    bits2(16);
    chk(frame, {4'h0, sample2});
    $display("late start done");
    give_verdict();
  end
endmodule
